// *** counter_channel_pkg.sv ***
// Constants and types for one counter channel
// What this block does
// - Mode write drives output high, stops counting, freezes residual count
// - After mode select, no counting until all preload bytes written
// - Mode 1: after preload, clock edges decrement residual count regardless of gate
// - Mode 1: gate edge arms; next clock fall loads counter, output low
// - Mode 1: gate edge before terminal count reloads; output stays low
// - Mode 1: count zero drives output high until the next gate trigger
// - Mode 1: after terminal count keep decrementing, binary or decimal
// - Modes 2, 3: first clock fall after preload loads counter, gate high or low
// - Mode 2: count one gives one-period low output, then reload
// - Modes 2, 3: gate low counts, gate high reloads on clock fall
// - Modes 2, 3: gate rise with output low forces high and reloads
// - Mode 2: preload zero is full range, preload one holds output high
// - Mode 3: preloads zero to three give the special periods
// - Mode 3: toggle and reload on clock fall after count two
// - Mode 3: even preload decrements by two each clock fall
// - Mode 3: odd preload steps one then two high, three then two low
// - Mode 4: first clock fall with gate loads; counts only while gate
// - Mode 4: count zero gives one-clock low strobe, then output high
// - Mode 4: after terminal count keep decrementing, never reload
// - Mode 5: as mode 1 but single one-clock low strobe at zero
// - Writes taken only with write strobe, io request and io expand
// - Two-byte preload: low byte first, start only after high byte
package counter_channel_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [2:0] ADDR_PRELOAD = 3'h0;
  localparam logic [2:0] ADDR_MODE = 3'h1;
  localparam logic [2:0] ADDR_CTRL = 3'h2;
  localparam logic [2:0] ADDR_COUNT_LO = 3'h3;
  localparam logic [2:0] ADDR_COUNT_HI = 3'h4;
  localparam logic [2:0] ADDR_STATUS = 3'h5;

  // ----------------------------------------
  // Fields and reset values
  // ----------------------------------------
  localparam int CTRL_GATE_ENABLE_BIT = 0;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [1:0] RL_LATCH = 2'h0;
  localparam logic [1:0] RL_LOW = 2'h1;
  localparam logic [1:0] RL_HIGH = 2'h2;
  localparam logic [1:0] RL_BOTH = 2'h3;

  // ----------------------------------------
  // Count values
  // ----------------------------------------
  localparam logic [15:0] TC_ZERO = 16'h0000;
  localparam logic [15:0] TC_ONE = 16'h0001;
  localparam logic [15:0] TC_TWO = 16'h0002;
  localparam logic [1:0] STEP_ONE = 2'h1;
  localparam logic [1:0] STEP_TWO = 2'h2;
  localparam logic [1:0] STEP_THREE = 2'h3;

  typedef enum logic [2:0] {
    MODE_0, MODE_1, MODE_2, MODE_3, MODE_4, MODE_5, MODE_6, MODE_7
  } mode_e;

  typedef struct packed {
    logic [1:0] unused;
    logic [1:0] read_load_field;
    mode_e mode;
    logic bcd;
  } mode_ctrl_s;

endpackage

// *** counter_channel.sv ***
// One 16-bit down-counter channel, modes 1 to 5
//
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module counter_channel
  import counter_channel_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic io_req_n,
  input wire logic io_expand,
  output logic [7:0] rdata,
  input wire logic count_clock,
  input wire logic gate,
  output logic out_n
);

  // ----------------------------------------
  // Decrement helpers
  // ----------------------------------------
  function automatic logic [15:0] bcd_dec1(input logic [15:0] v);
    logic [15:0] r;
    logic borrow;
    r = v;
    borrow = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      if (borrow)
      begin
        if (r[i*4 +: 4] == 4'h0)
          r[i*4 +: 4] = 4'h9;
        else
        begin
          r[i*4 +: 4] = r[i*4 +: 4] - 4'h1;
          borrow = 1'b0;
        end
      end
    end
    return r;
  endfunction

  // Wraps to FFFF or 9999 below zero
  function automatic logic [15:0] count_down(input logic [15:0] v, input logic [1:0] step,
                                             input logic bcd);
    logic [15:0] r;
    r = v;
    if (bcd)
    begin
      for (int i = 0; i < 3; i++)
        if (2'(i) < step)
          r = bcd_dec1(r);
    end
    else
      r = v - {14'h0000, step};
    return r;
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [1:0] clk_sync;
  logic [1:0] gate_sync;
  logic clk_last;
  logic gate_last;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      clk_sync <= 2'b00;
      gate_sync <= 2'b00;
      clk_last <= 1'b0;
      gate_last <= 1'b0;
    end
    else
    begin
      clk_sync <= {clk_sync[0], count_clock};
      gate_sync <= {gate_sync[0], gate};
      clk_last <= clk_sync[1];
      gate_last <= gate_sync[1];
    end
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  mode_ctrl_s mode_ctrl;
  logic gate_enable_bit;
  logic [15:0] preload;
  logic [15:0] count;
  logic high_next;
  logic loaded;
  logic need_load;
  logic armed;
  logic running;
  logic first_step;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire io_write = wr && !io_req_n && io_expand;
  wire write_mode = io_write && addr == ADDR_MODE;
  wire write_preload = io_write && addr == ADDR_PRELOAD;
  wire write_ctrl = io_write && addr == ADDR_CTRL;
  wire mode_ctrl_s new_mode = mode_ctrl_s'(wdata);
  wire take_mode = write_mode && new_mode.read_load_field != RL_LATCH;
  wire [1:0] rl = mode_ctrl.read_load_field;
  // Low byte first in two-byte transfer
  wire preload_done = write_preload && (rl != RL_BOTH || high_next);
  wire [15:0] next_preload =
    (rl == RL_LOW) ? {8'h00, wdata} :
    (rl == RL_HIGH) ? {wdata, 8'h00} :
    high_next ? {wdata, preload[7:0]} : {8'h00, wdata};

  wire gate_level = gate_sync[1] && gate_enable_bit;
  wire gate_rise = gate_sync[1] && !gate_last && gate_enable_bit;
  wire clk_fall = clk_last && !clk_sync[1];
  wire mode_e mode = mode_ctrl.mode;
  wire bcd = mode_ctrl.bcd;
  wire one_shot = mode == MODE_1 || mode == MODE_5;
  wire periodic = mode == MODE_2 || mode == MODE_3;

  // Mode 3 step size: odd preload starts each half with 1 (high) or 3 (low)
  wire odd_first = preload[0] && first_step;
  wire [1:0] sq_step = !odd_first ? STEP_TWO : (out_n ? STEP_ONE : STEP_THREE);
  wire [15:0] dec_one = count_down(count, STEP_ONE, bcd);
  wire [15:0] dec_sq = count_down(count, sq_step, bcd);

  // ----------------------------------------
  // Next counter state
  // ----------------------------------------
  logic [15:0] next_count;
  logic next_out_n;
  logic next_need_load;
  logic next_armed;
  logic next_running;
  logic next_first_step;

  always_comb
  begin
    next_count = count;
    next_out_n = out_n;
    next_need_load = need_load;
    next_armed = armed || (one_shot && gate_rise);
    next_running = running;
    next_first_step = first_step;
    if (periodic && gate_rise && !out_n)
    begin
      // Immediate, no wait for the counting clock
      next_out_n = 1'b1;
      next_count = preload;
      next_first_step = 1'b1;
    end
    else if (loaded && clk_fall)
    begin
      case (mode)
        MODE_1, MODE_5:
        begin
          if (armed)
          begin
            next_count = preload;
            next_out_n = (mode != MODE_1);
            next_running = 1'b1;
            next_armed = one_shot && gate_rise;
          end
          else
          begin
            next_count = dec_one;
            if (mode == MODE_5 && !out_n)
              next_out_n = 1'b1;
            if (running && dec_one == TC_ZERO)
            begin
              next_out_n = (mode == MODE_1);
              next_running = 1'b0;
            end
          end
        end
        MODE_2:
        begin
          if (need_load || gate_level || !out_n)
          begin
            next_count = preload;
            next_out_n = 1'b1;
            next_need_load = 1'b0;
          end
          else
          begin
            next_count = dec_one;
            if (dec_one == TC_ONE && preload != TC_ONE)
              next_out_n = 1'b0;
          end
        end
        MODE_3:
        begin
          if (need_load || gate_level)
          begin
            next_count = preload;
            next_out_n = 1'b1;
            next_need_load = 1'b0;
            next_first_step = 1'b1;
          end
          else if (count == TC_TWO)
          begin
            next_out_n = !out_n;
            next_count = preload;
            next_first_step = 1'b1;
          end
          else
          begin
            // Preload 0 and 1 run through the wrap for the extra-long periods
            next_count = dec_sq;
            next_first_step = 1'b0;
          end
        end
        MODE_4:
        begin
          if (!out_n)
            next_out_n = 1'b1;
          if (gate_level)
          begin
            if (need_load)
            begin
              next_count = preload;
              next_need_load = 1'b0;
            end
            else
            begin
              next_count = dec_one;
              if (running && dec_one == TC_ZERO)
              begin
                next_out_n = 1'b0;
                next_running = 1'b0;
              end
            end
          end
        end
        default:
        begin
          next_count = count;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      mode_ctrl <= mode_ctrl_s'(MODE_RESET);
      gate_enable_bit <= 1'b0;
      preload <= COUNT_RESET;
      high_next <= 1'b0;
      loaded <= 1'b0;
      need_load <= 1'b0;
      armed <= 1'b0;
      running <= 1'b0;
      first_step <= 1'b0;
      count <= COUNT_RESET;
      out_n <= 1'b1;
    end
    else if (take_mode)
    begin
      // Count stays as the previous mode left it
      mode_ctrl <= new_mode;
      out_n <= 1'b1;
      loaded <= 1'b0;
      high_next <= 1'b0;
      need_load <= 1'b0;
      armed <= 1'b0;
      running <= 1'b0;
      if (write_ctrl)
        gate_enable_bit <= wdata[CTRL_GATE_ENABLE_BIT];
    end
    else
    begin
      if (write_ctrl)
        gate_enable_bit <= wdata[CTRL_GATE_ENABLE_BIT];
      count <= next_count;
      out_n <= next_out_n;
      armed <= next_armed;
      first_step <= next_first_step;
      if (write_preload)
      begin
        preload <= next_preload;
        high_next <= (rl == RL_BOTH) && !high_next;
      end
      if (preload_done)
      begin
        loaded <= 1'b1;
        need_load <= 1'b1;
        running <= (mode == MODE_4);
      end
      else
      begin
        need_load <= next_need_load;
        running <= next_running;
      end
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  wire [7:0] status = {5'h00, running, loaded, out_n};
  logic [7:0] read_value;

  always_comb
  begin
    if (addr == ADDR_MODE)
      read_value = mode_ctrl;
    else if (addr == ADDR_CTRL)
      read_value = {7'h00, gate_enable_bit};
    else if (addr == ADDR_COUNT_LO)
      read_value = count[7:0];
    else if (addr == ADDR_COUNT_HI)
      read_value = count[15:8];
    else if (addr == ADDR_STATUS)
      read_value = status;
    else
      read_value = 8'h00;
  end

  // Data valid only in the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rdata <= 8'h00;
    else if (rd)
      rdata <= read_value;
    else
      rdata <= 8'h00;
  end

endmodule // counter_channel

// *** clock_pin_source.sv ***
// Counting clock pin source driven beside the counter channel
`timescale 1ns/1ps
module clock_pin_source
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic fire,
  output logic count_clock
);
  // ----------------------------------------
  // One falling pulse per request
  // ----------------------------------------
  logic [2:0] hold;

  // Pin rests high between pulses, so no stray falls reach the channel
  always_ff @(posedge clk)
  begin
    if (!rst_n || (!fire && hold == 3'h0))
      count_clock <= 1'b1;
    else if (fire)
      count_clock <= 1'b0;
  end

  // Low phase kept five cycles, well above the two-cycle minimum
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      hold <= 3'h0;
    else if (fire)
      hold <= 3'h4;
    else if (hold != 3'h0)
      hold <= hold - 3'h1;
  end
endmodule // clock_pin_source

// *** counter_channel_props.sv ***
// Port checker for the counter channel
`timescale 1ns/1ps
module counter_channel_props
  import counter_channel_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic io_req_n,
  input wire logic io_expand,
  input wire logic [7:0] rdata,
  input wire logic count_clock,
  input wire logic gate,
  input wire logic out_n
);
  // ----------------------------------------
  // Shadow of accepted host writes
  // ----------------------------------------
  logic [7:0] mode_sh;
  logic gen, pend, half, done4, cc_d;
  logic [3:0] age;
  wire wr_ok = wr && !io_req_n && io_expand;
  wire mode_wr = wr_ok && addr == ADDR_MODE && wdata[5:4] != 2'h0;
  wire pre_wr = wr_ok && addr == ADDR_PRELOAD;
  wire live_sel = wdata[3:1] != 3'h0 && wdata[3:1] < 3'h6;
  wire m23 = mode_sh[3:1] == 3'h2 || mode_sh[3:1] == 3'h3;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      mode_sh <= MODE_RESET;
      gen <= 1'b0;
    end
    else if (mode_wr)
      mode_sh <= wdata;
    else if (wr_ok && addr == ADDR_CTRL)
      gen <= wdata[0];
  end

  // Pending until the last preload byte, so two-byte loads count twice
  always_ff @(posedge clk)
  begin
    if (!rst_n || mode_wr)
      half <= 1'b0;
    else if (pre_wr && mode_sh[5:4] == RL_BOTH)
      half <= !half;
    if (!rst_n)
      pend <= 1'b0;
    else if (mode_wr)
      pend <= live_sel;
    else if (pre_wr && (mode_sh[5:4] != RL_BOTH || half))
      pend <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    cc_d <= count_clock;
    if (!rst_n)
      age <= 4'hF;
    else if (cc_d && !count_clock)
      age <= 4'h0;
    else if (age != 4'hF)
      age <= age + 4'h1;
    if (!rst_n || mode_wr || pre_wr)
      done4 <= 1'b0;
    else if (mode_sh[3:1] == 3'h4 && !pend && $rose(out_n))
      done4 <= 1'b1;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_read_idle: assert property (!rd |=> rdata == 8'h00)
    else $error("rdata not idle");
  chk_mode_out: assert property (mode_wr && live_sel |-> ##[1:2] out_n)
    else $error("out_n low after mode select");
  chk_preload_hold: assert property (pend |-> ##1 out_n)
    else $error("out_n moved before preload");
  chk_fall_cause: assert property ($fell(out_n) |-> age < 4'h8)
    else $error("out_n fell without clock fall");
  chk_gate_force: assert property (m23 && gen && $rose(gate) && !out_n |-> ##[1:6] out_n)
    else $error("gate rise did not force out_n high");
  chk_strobe_once: assert property (done4 |-> out_n)
    else $error("second strobe after terminal count");
  chk_unmapped_rd: assert property (rd && addr > 3'h5 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_mode_back: assert property (rd && addr == ADDR_MODE |=> rdata[5:0] == mode_sh[5:0])
    else $error("mode byte readback wrong");
endmodule // counter_channel_props

bind counter_channel counter_channel_props chk (.clk(clk), .rst_n(rst_n), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .io_req_n(io_req_n), .io_expand(io_expand),
  .rdata(rdata), .count_clock(count_clock), .gate(gate), .out_n(out_n));

// *** counter_channel_test.sv ***
// Self-checking testbench for the counter channel
`timescale 1ns/1ps
module counter_channel_test
  import counter_channel_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic io_req_n = 1'b0;
  logic io_expand = 1'b1;
  logic gate = 1'b0;
  logic fire = 1'b0;
  logic [7:0] rdata, rv, lo;
  logic count_clock, out_n;
  int fail_count = 0;
  int tests_run = 0;

  always #12.5 clk = ~clk;

  counter_channel dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .io_req_n(io_req_n), .io_expand(io_expand), .rdata(rdata),
    .count_clock(count_clock), .gate(gate), .out_n(out_n));
  clock_pin_source pins (.clk(clk), .rst_n(rst_n), .fire(fire), .count_clock(count_clock));

  // ----------------------------------------
  // Bus and pin tasks
  // ----------------------------------------
  task automatic wreg(input logic [2:0] a, input logic [7:0] d, input logic ok);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    io_req_n <= !ok;
    @(posedge clk);
    wr <= 1'b0;
    io_req_n <= 1'b0;
  endtask

  task automatic rreg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic setg(input logic v);
    @(posedge clk);
    gate <= v;
    repeat (8) @(posedge clk);
  endtask

  // One counting pulse, then count and output compared
  task automatic step(input logic [15:0] c, input logic o);
    @(posedge clk);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (10) @(posedge clk);
    rreg(ADDR_COUNT_LO, lo);
    rreg(ADDR_COUNT_HI, rv);
    check("count", c, {rv, lo});
    check("out_n", {15'h0000, o}, {15'h0000, out_n});
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    wreg(ADDR_MODE, 8'h32, 1'b0);
    rreg(ADDR_MODE, rv);
    check("mode", 16'h0000, {8'h00, rv});
    // Refused again with io expand low
    io_expand <= 1'b0;
    wreg(ADDR_MODE, 8'h32, 1'b1);
    io_expand <= 1'b1;
    rreg(ADDR_MODE, rv);
    check("mode", 16'h0000, {8'h00, rv});
    wreg(ADDR_CTRL, 8'h00, 1'b1);
    wreg(ADDR_MODE, 8'h32, 1'b1);
    rreg(ADDR_MODE, rv);
    check("mode", 16'h0032, {8'h00, rv});
    check("out_n", 16'h0001, {15'h0000, out_n});
    wreg(ADDR_PRELOAD, 8'h03, 1'b1);
    step(16'h0000, 1'b1);
    wreg(ADDR_PRELOAD, 8'h00, 1'b1);
    step(16'hFFFF, 1'b1);
    wreg(ADDR_CTRL, 8'h01, 1'b1);
    setg(1'b1);
    step(16'h0003, 1'b0);
    step(16'h0002, 1'b0);
    setg(1'b0);
    setg(1'b1);
    step(16'h0003, 1'b0);
    step(16'h0002, 1'b0);
    step(16'h0001, 1'b0);
    step(16'h0000, 1'b1);
    step(16'hFFFF, 1'b1);
    // Mode 2, gate still high so the first fall loads
    wreg(ADDR_MODE, 8'h14, 1'b1);
    wreg(ADDR_PRELOAD, 8'h03, 1'b1);
    step(16'h0003, 1'b1);
    setg(1'b0);
    step(16'h0002, 1'b1);
    step(16'h0001, 1'b0);
    step(16'h0003, 1'b1);
    step(16'h0002, 1'b1);
    step(16'h0001, 1'b0);
    setg(1'b1);
    check("out_n", 16'h0001, {15'h0000, out_n});
    step(16'h0003, 1'b1);
    // Mode 4
    wreg(ADDR_MODE, 8'h18, 1'b1);
    wreg(ADDR_PRELOAD, 8'h02, 1'b1);
    step(16'h0002, 1'b1);
    setg(1'b0);
    step(16'h0002, 1'b1);
    setg(1'b1);
    step(16'h0001, 1'b1);
    step(16'h0000, 1'b0);
    step(16'hFFFF, 1'b1);
    // Mode 3: even preload, then odd, then divide by two
    wreg(ADDR_MODE, 8'h16, 1'b1);
    wreg(ADDR_PRELOAD, 8'h04, 1'b1);
    step(16'h0004, 1'b1);
    setg(1'b0);
    step(16'h0002, 1'b1);
    step(16'h0004, 1'b0);
    step(16'h0002, 1'b0);
    step(16'h0004, 1'b1);
    wreg(ADDR_PRELOAD, 8'h05, 1'b1);
    step(16'h0005, 1'b1);
    step(16'h0004, 1'b1);
    step(16'h0002, 1'b1);
    step(16'h0005, 1'b0);
    step(16'h0002, 1'b0);
    step(16'h0005, 1'b1);
    wreg(ADDR_PRELOAD, 8'h02, 1'b1);
    step(16'h0002, 1'b1);
    step(16'h0002, 1'b0);
    step(16'h0002, 1'b1);
    step(16'h0002, 1'b0);
    // Mode 5, selected while the output is low
    wreg(ADDR_CTRL, 8'h00, 1'b1);
    wreg(ADDR_MODE, 8'h1A, 1'b1);
    wreg(ADDR_PRELOAD, 8'h02, 1'b1);
    check("out_n", 16'h0001, {15'h0000, out_n});
    wreg(ADDR_CTRL, 8'h01, 1'b1);
    setg(1'b1);
    step(16'h0002, 1'b1);
    step(16'h0001, 1'b1);
    step(16'h0000, 1'b0);
    step(16'hFFFF, 1'b1);
    // Mode 4 in decimal, high byte only
    wreg(ADDR_MODE, 8'h29, 1'b1);
    wreg(ADDR_PRELOAD, 8'h01, 1'b1);
    step(16'h0100, 1'b1);
    step(16'h0099, 1'b1);
    rreg(3'h7, rv);
    check("unmapped", 16'h0000, {8'h00, rv});
    close_out;
  end

  // Whole sequence needs about 820 cycles
  initial
  begin
    repeat (10000) @(posedge clk);
    fail_count++;
    close_out;
  end
endmodule // counter_channel_test
